// *** hdl/pirq_consts.svh ***
// Offsets, field positions, reset values and counts for the peripheral interrupt routing block.
`ifndef PIRQ_CONSTS_SVH
`define PIRQ_CONSTS_SVH

`define PIRQ_NUM_LINES      32
`define PIRQ_NUM_PERIPH     28
`define PIRQ_PRIO_BITS      2
`define PIRQ_FLAG_WIDTH     16

// Counter peripheral registers.
`define PIRQ_CNT_ENCLR_OFS  8'h08
`define PIRQ_CNT_ENSET_OFS  8'h0c
`define PIRQ_CNT_FLAG_OFS   8'h10
`define PIRQ_CNT_MODE_OFS   8'h00
`define PIRQ_CNT_ENCLR_RST  16'h0000
`define PIRQ_CNT_ENCLR_MASK 16'h83ff
`define PIRQ_CNT_MODE_RST   2'h0
`define PIRQ_CNT_MODE_C16   2'h1
`define PIRQ_CNT_OVERFLOW_BIT 15
`define PIRQ_CNT_LINE       2

// Controller registers.
`define PIRQ_LEN_SET_OFS    8'h40
`define PIRQ_LEN_CLR_OFS    8'h44
`define PIRQ_PEND_SET_OFS   8'h48
`define PIRQ_PEND_CLR_OFS   8'h4c
`define PIRQ_ACTIVE_OFS     8'h50
`define PIRQ_PRIO_OFS       8'h60
`define PIRQ_PRIO_COUNT     8
`define PIRQ_NONE_ID        6'h3f

`endif

// *** hdl/pirq_pkg.sv ***
// Types shared by the peripheral interrupt routing block.
package pirq_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } pirq_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } pirq_wb_rsp_s;

    typedef enum logic [1:0] {
        PIRQ_IDLE = 2'b00,
        PIRQ_ACK  = 2'b01
    } pirq_bus_e;

endpackage

// *** hdl/pirq_src.sv ***
// One peripheral interrupt source: sticky flags, one enable per flag, one OR-ed request.
`timescale 1ns/1ns
`include "pirq_consts.svh"
module pirq_src #(
    parameter int W = `PIRQ_FLAG_WIDTH
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic [W-1:0] event_in,
    input  wire logic [W-1:0] flag_clr_in,
    input  wire logic [W-1:0] en_set_in,
    input  wire logic [W-1:0] en_clr_in,
    output logic      [W-1:0] flag_out,
    output logic      [W-1:0] enable_out,
    output logic              req_out
);
    if (W < 1) begin : g_bad_width
        $error("pirq_src width must be at least one");
    end

    logic [W-1:0] flag_ff;
    logic [W-1:0] en_ff;
    logic [W-1:0] nxt_flag;
    logic [W-1:0] nxt_en;

    always_comb begin
        // An event in the same cycle as its clear wins, so no condition is lost.
        nxt_flag = (flag_ff & ~flag_clr_in) | event_in;
        nxt_en   = (en_ff | en_set_in) & ~en_clr_in;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flag_ff <= '0;
            en_ff   <= '0;
        end else begin
            flag_ff <= nxt_flag;
            en_ff   <= nxt_en;
        end
    end

    assign flag_out   = flag_ff;
    assign enable_out = en_ff;
    assign req_out    = |(flag_ff & en_ff);
endmodule // pirq_src

// *** hdl/pirq_line.sv ***
// One controller line: pending bit, line enable and priority field.
`timescale 1ns/1ns
module pirq_line #(
    parameter int PW = 2
) (
    input  wire logic          clk_in,
    input  wire logic          resetn_in,
    input  wire logic          req_in,
    input  wire logic          pend_set_in,
    input  wire logic          pend_clr_in,
    input  wire logic          en_set_in,
    input  wire logic          en_clr_in,
    input  wire logic          prio_wr_in,
    input  wire logic [PW-1:0] prio_in,
    output logic               pend_out,
    output logic               en_out,
    output logic      [PW-1:0] prio_out,
    output logic               active_out
);
    if (PW < 1) begin : g_bad_width
        $error("pirq_line priority width must be at least one");
    end

    logic          pend_ff;
    logic          en_ff;
    logic [PW-1:0] prio_ff;
    logic          nxt_pend;
    logic          nxt_en;
    logic [PW-1:0] nxt_prio;

    always_comb begin
        // Request and software set both beat a software clear in the same cycle.
        nxt_pend = (pend_ff & ~pend_clr_in) | req_in | pend_set_in;
        nxt_en   = (en_ff & ~en_clr_in) | en_set_in;
        nxt_prio = prio_wr_in ? prio_in : prio_ff;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pend_ff <= 1'b0;
            en_ff   <= 1'b0;
            prio_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
            en_ff   <= nxt_en;
            prio_ff <= nxt_prio;
        end
    end

    assign pend_out   = pend_ff;
    assign en_out     = en_ff;
    assign prio_out   = prio_ff;
    assign active_out = pend_ff & en_ff;
endmodule // pirq_line

// *** hdl/pirq_top.sv ***
// Peripheral interrupt routing: counter enable registers, line map and controller registers.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "pirq_consts.svh"
module pirq_top #(
    parameter int NUM_LINES = `PIRQ_NUM_LINES,
    parameter int PRIO_BITS = `PIRQ_PRIO_BITS
) (
    input  wire logic                   CORE_CLK_IN,
    input  wire logic                   RESETN_IN,
    input  wire pirq_pkg::pirq_wb_req_s WB_REQ_IN,
    output pirq_pkg::pirq_wb_rsp_s      WB_RSP_OUT,
    input  wire logic [5:0]             SYSCTL_REQ_IN,
    input  wire logic                   WATCHDOG_REQ_IN,
    input  wire logic [15:0]            CNT_EVENT_IN,
    input  wire logic                   EXT_REQ_IN,
    input  wire logic                   EXT_NMI_IN,
    input  wire logic                   NVM_REQ_IN,
    input  wire logic                   DMA_REQ_IN,
    input  wire logic                   USB_REQ_IN,
    input  wire logic                   EVENT_REQ_IN,
    input  wire logic [19:0]            OTHER_REQ_IN,
    output logic                        CORE_NMI_OUT,
    output logic                        CORE_IRQ_OUT,
    output logic [5:0]                  CORE_IRQ_ID_OUT,
    output logic [1:0]                  CORE_IRQ_PRIO_OUT,
    output logic [NUM_LINES-1:0]        LINE_ACTIVE_OUT
);
    import pirq_pkg::*;

    // The line map and the register layout are fixed, so other sizes are refused.
    if (NUM_LINES != `PIRQ_NUM_LINES) begin : g_bad_lines
        $error("pirq_top serves exactly 32 lines");
    end
    if (PRIO_BITS != `PIRQ_PRIO_BITS) begin : g_bad_prio
        $error("pirq_top serves exactly four priority levels");
    end

    localparam int NPRIO = 1 << PRIO_BITS;

    // Bus decode.
    logic        acc;
    logic        wr;
    logic [31:0] wmask;
    logic [31:0] wdat;
    pirq_bus_e   bus_ff;
    pirq_bus_e   nxt_bus;
    logic [31:0] rdat_ff;
    logic [31:0] nxt_rdat;

    assign acc   = WB_REQ_IN.cyc & WB_REQ_IN.stb & (bus_ff == PIRQ_IDLE);
    assign wr    = acc & WB_REQ_IN.we;
    assign wmask = {{8{WB_REQ_IN.sel[3]}}, {8{WB_REQ_IN.sel[2]}}, {8{WB_REQ_IN.sel[1]}}, {8{WB_REQ_IN.sel[0]}}};
    assign wdat  = WB_REQ_IN.dat & wmask;

    // Counter peripheral mode and its flag and enable state.
    logic [1:0]  mode_ff;
    logic [1:0]  nxt_mode;
    logic        c16;
    logic [15:0] cnt_flag;
    logic [15:0] cnt_en;
    logic [15:0] cnt_en_set;
    logic [15:0] cnt_en_clr;
    logic [15:0] cnt_flag_clr;
    logic        cnt_req;

    assign c16 = (mode_ff == `PIRQ_CNT_MODE_C16);

    always_comb begin
        nxt_mode = mode_ff;
        if (wr && WB_REQ_IN.adr == `PIRQ_CNT_MODE_OFS && WB_REQ_IN.sel[0]) begin
            nxt_mode = WB_REQ_IN.dat[1:0];
        end
    end

    always_comb begin
        cnt_en_set   = 16'h0000;
        cnt_en_clr   = 16'h0000;
        cnt_flag_clr = 16'h0000;
        // The enable registers only take writes in sixteen-bit mode; flag clears are taken in every mode.
        if (wr && c16 && WB_REQ_IN.adr == `PIRQ_CNT_ENCLR_OFS) begin
            cnt_en_clr = wdat[15:0] & `PIRQ_CNT_ENCLR_MASK;
        end
        if (wr && c16 && WB_REQ_IN.adr == `PIRQ_CNT_ENSET_OFS) begin
            cnt_en_set = wdat[15:0] & `PIRQ_CNT_ENCLR_MASK;
        end
        if (wr && WB_REQ_IN.adr == `PIRQ_CNT_FLAG_OFS) begin
            cnt_flag_clr = wdat[15:0];
        end
    end

    pirq_src #(
        .W(16)
    ) u_cnt (
        .clk_in      (CORE_CLK_IN),
        .resetn_in   (RESETN_IN),
        .event_in    (CNT_EVENT_IN & `PIRQ_CNT_ENCLR_MASK),
        .flag_clr_in (cnt_flag_clr),
        .en_set_in   (cnt_en_set),
        .en_clr_in   (cnt_en_clr),
        .flag_out    (cnt_flag),
        .enable_out  (cnt_en),
        .req_out     (cnt_req)
    );

    // Line map: system control units share line 0, the rest one line each.
    logic [NUM_LINES-1:0] line_req;
    always_comb begin
        line_req        = '0;
        line_req[0]     = |SYSCTL_REQ_IN;
        line_req[1]     = WATCHDOG_REQ_IN;
        line_req[`PIRQ_CNT_LINE] = cnt_req;
        line_req[3]     = EXT_REQ_IN;
        line_req[4]     = NVM_REQ_IN;
        line_req[5]     = DMA_REQ_IN;
        line_req[6]     = USB_REQ_IN;
        line_req[7]     = EVENT_REQ_IN;
        // Lines 8 to 27 carry the remaining peripherals; 28 to 31 stay unwired.
        line_req[`PIRQ_NUM_PERIPH-1:8] = OTHER_REQ_IN;
    end

    // The non-maskable source bypasses the numbered lines entirely.
    assign CORE_NMI_OUT = EXT_NMI_IN;

    // Controller register strobes.
    logic [NUM_LINES-1:0] pend_set;
    logic [NUM_LINES-1:0] pend_clr;
    logic [NUM_LINES-1:0] len_set;
    logic [NUM_LINES-1:0] len_clr;
    logic [NUM_LINES-1:0] prio_wr;
    logic [NUM_LINES-1:0] pend;
    logic [NUM_LINES-1:0] len;
    logic [NUM_LINES-1:0] act;
    logic [PRIO_BITS-1:0] prio [NUM_LINES];
    logic [2:0]           prio_idx;
    logic                 prio_hit;

    // Priority words cover eight consecutive word addresses, four lines per word.
    assign prio_hit = (WB_REQ_IN.adr >= `PIRQ_PRIO_OFS) &&
                      (WB_REQ_IN.adr < (`PIRQ_PRIO_OFS + 8'(4 * `PIRQ_PRIO_COUNT)));
    assign prio_idx = 3'((WB_REQ_IN.adr - `PIRQ_PRIO_OFS) >> 2);

    always_comb begin
        pend_set = '0;
        pend_clr = '0;
        len_set  = '0;
        len_clr  = '0;
        prio_wr  = '0;
        if (wr && WB_REQ_IN.adr == `PIRQ_LEN_SET_OFS) begin
            len_set = wdat;
        end else if (wr && WB_REQ_IN.adr == `PIRQ_LEN_CLR_OFS) begin
            len_clr = wdat;
        end else if (wr && WB_REQ_IN.adr == `PIRQ_PEND_SET_OFS) begin
            pend_set = wdat;
        end else if (wr && WB_REQ_IN.adr == `PIRQ_PEND_CLR_OFS) begin
            pend_clr = wdat;
        end else if (wr && prio_hit) begin
            // Each byte lane of a priority word holds one line's field in its top bits.
            for (int b = 0; b < 4; b++) begin
                prio_wr[prio_idx * 4 + b] = WB_REQ_IN.sel[b];
            end
        end
    end

    for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
        pirq_line #(
            .PW(PRIO_BITS)
        ) u_line (
            .clk_in      (CORE_CLK_IN),
            .resetn_in   (RESETN_IN),
            .req_in      (line_req[i]),
            .pend_set_in (pend_set[i]),
            .pend_clr_in (pend_clr[i]),
            .en_set_in   (len_set[i]),
            .en_clr_in   (len_clr[i]),
            .prio_wr_in  (prio_wr[i]),
            .prio_in     (WB_REQ_IN.dat[(i % 4) * 8 + 6 +: 2]),
            .pend_out    (pend[i]),
            .en_out      (len[i]),
            .prio_out    (prio[i]),
            .active_out  (act[i])
        );
    end

    assign LINE_ACTIVE_OUT = act;

    // Arbitration: lowest priority value wins, then lowest line number.
    logic [5:0]           win_id;
    logic [PRIO_BITS-1:0] win_prio;
    logic                 win_any;
    always_comb begin
        win_id   = `PIRQ_NONE_ID;
        win_prio = PRIO_BITS'(NPRIO - 1);
        win_any  = 1'b0;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (act[i] && (!win_any || prio[i] < win_prio)) begin
                win_any  = 1'b1;
                win_prio = prio[i];
                win_id   = 6'(i);
            end
        end
    end

    // Core request group. Registering the winner costs one cycle of latency but
    // hands the core a line number and priority that never glitch within a cycle.
    logic       irq_ff;
    logic [5:0] id_ff;
    logic [1:0] pr_ff;
    logic       nxt_irq;
    logic [5:0] nxt_id;
    logic [1:0] nxt_pr;

    always_comb begin
        nxt_irq = win_any;
        nxt_id  = win_id;
        nxt_pr  = win_prio;
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            irq_ff <= 1'b0;
            id_ff  <= `PIRQ_NONE_ID;
            pr_ff  <= 2'h0;
        end else begin
            irq_ff <= nxt_irq;
            id_ff  <= nxt_id;
            pr_ff  <= nxt_pr;
        end
    end

    assign CORE_IRQ_OUT      = irq_ff;
    assign CORE_IRQ_ID_OUT   = id_ff;
    assign CORE_IRQ_PRIO_OUT = pr_ff;

    // Read decode of every register word; unmapped words read as zero.
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h00000000;
        if (WB_REQ_IN.adr == `PIRQ_CNT_MODE_OFS) begin
            rd_word = {30'h00000000, mode_ff};
        end else if (WB_REQ_IN.adr == `PIRQ_CNT_ENCLR_OFS || WB_REQ_IN.adr == `PIRQ_CNT_ENSET_OFS) begin
            rd_word = {16'h0000, cnt_en & `PIRQ_CNT_ENCLR_MASK};
        end else if (WB_REQ_IN.adr == `PIRQ_CNT_FLAG_OFS) begin
            rd_word = {16'h0000, cnt_flag};
        end else if (WB_REQ_IN.adr == `PIRQ_LEN_SET_OFS || WB_REQ_IN.adr == `PIRQ_LEN_CLR_OFS) begin
            rd_word = len;
        end else if (WB_REQ_IN.adr == `PIRQ_PEND_SET_OFS || WB_REQ_IN.adr == `PIRQ_PEND_CLR_OFS) begin
            rd_word = pend;
        end else if (WB_REQ_IN.adr == `PIRQ_ACTIVE_OFS) begin
            rd_word = act;
        end else if (prio_hit) begin
            for (int b = 0; b < 4; b++) begin
                rd_word[b * 8 + 6 +: 2] = prio[prio_idx * 4 + b];
            end
        end
    end

    // Read data group. The word is captured only when a request is taken, so it
    // stands unchanged for the whole acknowledge cycle and the data lines stay quiet after it.
    always_comb begin
        nxt_rdat = rdat_ff;
        if (acc) begin
            nxt_rdat = rd_word;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rdat_ff <= 32'h00000000;
        end else begin
            rdat_ff <= nxt_rdat;
        end
    end

    // Bus state group: one wait state, then a single-cycle acknowledge.
    always_comb begin
        nxt_bus = PIRQ_IDLE;
        if (acc) begin
            nxt_bus = PIRQ_ACK;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            bus_ff <= PIRQ_IDLE;
        end else begin
            bus_ff <= nxt_bus;
        end
    end

    // Counter mode group. Only the two low bits exist; the rest of that word reads as zero.
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            mode_ff <= `PIRQ_CNT_MODE_RST;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    assign WB_RSP_OUT.ack = (bus_ff == PIRQ_ACK);
    assign WB_RSP_OUT.dat = rdat_ff;
endmodule // pirq_top

// *** bench/pirq_src_model.sv ***
// Peripheral event source model that fires one-cycle condition pulses into the counter.
`timescale 1ns/1ns
module pirq_src_model (
    input  wire logic        clk_in,
    output logic      [15:0] event_out
);
    initial event_out = 16'h0000;
    // A condition lasts one cycle only, so the flag must hold it afterwards by itself.
    task automatic pulse(input logic [15:0] bits);
        @(posedge clk_in);
        event_out <= bits;
        @(posedge clk_in);
        event_out <= 16'h0000;
    endtask
endmodule // pirq_src_model

// *** bench/pirq_top_sva.sv ***
// Port checker for the interrupt routing top, bound into every instance.
`timescale 1ns/1ns
module pirq_top_sva #(
    parameter int NUM_LINES = 32,
    parameter int PRIO_BITS = 2
) (
    input wire logic                   CORE_CLK_IN,
    input wire logic                   RESETN_IN,
    input wire pirq_pkg::pirq_wb_req_s WB_REQ_IN,
    input wire pirq_pkg::pirq_wb_rsp_s WB_RSP_OUT,
    input wire logic                   EXT_NMI_IN,
    input wire logic                   CORE_NMI_OUT,
    input wire logic                   CORE_IRQ_OUT,
    input wire logic [5:0]             CORE_IRQ_ID_OUT,
    input wire logic [NUM_LINES-1:0]   LINE_ACTIVE_OUT
);
    import pirq_pkg::*;
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    a_nmi_follow: assert property (CORE_NMI_OUT == EXT_NMI_IN)
        else $error("non-maskable output differs from its source");
    a_ack_timing: assert property (WB_REQ_IN.cyc && WB_REQ_IN.stb && !WB_RSP_OUT.ack |=> WB_RSP_OUT.ack)
        else $error("request not answered one cycle after it was taken");
    a_ack_pulse: assert property (WB_RSP_OUT.ack |=> !WB_RSP_OUT.ack)
        else $error("ack lasted more than one cycle");
    a_ack_cause: assert property (WB_RSP_OUT.ack |-> $past(WB_REQ_IN.cyc) && $past(WB_REQ_IN.stb))
        else $error("ack without a request");
    a_irq_set: assert property ((|LINE_ACTIVE_OUT) |=> CORE_IRQ_OUT)
        else $error("active line did not raise the core request");
    a_irq_clear: assert property (!(|LINE_ACTIVE_OUT) |=> !CORE_IRQ_OUT)
        else $error("core request without an active line");
    a_id_none: assert property (!CORE_IRQ_OUT |-> CORE_IRQ_ID_OUT == 6'h3f)
        else $error("line number shown while no request");
    a_id_active: assert property (CORE_IRQ_OUT |-> CORE_IRQ_ID_OUT < 6'd32
        && (($past(LINE_ACTIVE_OUT) >> CORE_IRQ_ID_OUT[4:0]) & 1))
        else $error("winning line was not active");
endmodule // pirq_top_sva

bind pirq_top pirq_top_sva #(.NUM_LINES(NUM_LINES), .PRIO_BITS(PRIO_BITS)) u_sva (
    .CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN), .WB_REQ_IN(WB_REQ_IN), .WB_RSP_OUT(WB_RSP_OUT),
    .EXT_NMI_IN(EXT_NMI_IN), .CORE_NMI_OUT(CORE_NMI_OUT), .CORE_IRQ_OUT(CORE_IRQ_OUT),
    .CORE_IRQ_ID_OUT(CORE_IRQ_ID_OUT), .LINE_ACTIVE_OUT(LINE_ACTIVE_OUT));

// *** bench/test_peripheral_interrupt_routing.sv ***
// Self-checking bench for the interrupt routing block over its register bus and request pins.
`timescale 1ns/1ns
module test_peripheral_interrupt_routing;
    import pirq_pkg::*;
    logic         clk = 1'b0;
    logic         resetn = 1'b0;
    pirq_wb_req_s req = '0;
    pirq_wb_rsp_s rsp;
    logic [5:0]   sys = 6'h00;
    logic         wdog = 1'b0, ext = 1'b0, nvm = 1'b0, dma = 1'b0, usb = 1'b0, evs = 1'b0, nmi = 1'b0;
    logic [19:0]  oth = 20'h00000;
    logic [15:0]  ev;
    logic         nmi_o, irq;
    logic [5:0]   id;
    logic [1:0]   prio;
    logic [31:0]  act, rd;
    int           mismatches = 0;
    int           cmp_count = 0;
    int           lines [13] = '{0, 0, 0, 0, 0, 0, 1, 3, 4, 5, 6, 7, 8};

    always #4 clk = ~clk;

    pirq_src_model u_src (.clk_in(clk), .event_out(ev));
    pirq_top u_dut (.CORE_CLK_IN(clk), .RESETN_IN(resetn), .WB_REQ_IN(req), .WB_RSP_OUT(rsp),
        .SYSCTL_REQ_IN(sys), .WATCHDOG_REQ_IN(wdog), .CNT_EVENT_IN(ev), .EXT_REQ_IN(ext), .EXT_NMI_IN(nmi),
        .NVM_REQ_IN(nvm), .DMA_REQ_IN(dma), .USB_REQ_IN(usb), .EVENT_REQ_IN(evs), .OTHER_REQ_IN(oth),
        .CORE_NMI_OUT(nmi_o), .CORE_IRQ_OUT(irq), .CORE_IRQ_ID_OUT(id), .CORE_IRQ_PRIO_OUT(prio),
        .LINE_ACTIVE_OUT(act));

    task automatic end_of_test;
        $display("Mismatches %0d, compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Holds the whole request until ack is sampled, then leaves one idle cycle.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, 4'hf, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h1, 32'h0);
        r = rsp.dat;
        req <= '0;
        @(posedge clk);
    endtask

    task automatic set_src(input int k, input logic v);
        if (k < 6) sys[k] <= v;
        else case (k)
            6: wdog <= v;
            7: ext <= v;
            8: nvm <= v;
            9: dma <= v;
            10: usb <= v;
            11: evs <= v;
            default: oth[0] <= v;
        endcase
    endtask

    task automatic t_reset;
        wb(1'b0, 8'h08, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'b0, 8'hf0, 32'h0, rd);
        chk(rd, 32'h0);
        chk(id, 32'h3f);
    endtask

    task automatic t_cnt_regs;
        wb(1'b1, 8'h0c, 32'hffff, rd);
        wb(1'b0, 8'h08, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'b1, 8'h00, 32'h1, rd);
        wb(1'b1, 8'h0c, 32'hffff, rd);
        wb(1'b0, 8'h08, 32'h0, rd);
        chk(rd, 32'h83ff);
        wb(1'b1, 8'h08, 32'h0001, rd);
        wb(1'b0, 8'h08, 32'h0, rd);
        chk(rd, 32'h83fe);
        wb(1'b1, 8'h08, 32'h8300, rd);
        wb(1'b1, 8'h08, 32'h0000, rd);
        wb(1'b0, 8'h08, 32'h0, rd);
        chk(rd, 32'h00fe);
    endtask

    task automatic t_cnt_irq;
        wb(1'b1, 8'h40, 32'h4, rd);
        u_src.pulse(16'h8000);
        cyc(4);
        chk(irq, 32'h0);
        wb(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h8000);
        u_src.pulse(16'h0002);
        cyc(4);
        chk({irq, id}, {1'b1, 6'd2});
        wb(1'b1, 8'h10, 32'h0002, rd);
        wb(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h8000);
        wb(1'b1, 8'h10, 32'h8000, rd);
        wb(1'b1, 8'h4c, 32'h4, rd);
        cyc(3);
        chk(irq, 32'h0);
        wb(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h0);
    endtask

    // Levels stay pending after the source drops, so each pass clears its own line.
    task automatic t_map;
        wb(1'b1, 8'h40, 32'h1ff, rd);
        for (int k = 0; k < 13; k++) begin
            set_src(k, 1'b1);
            cyc(4);
            chk({irq, id}, {1'b1, lines[k][5:0]});
            set_src(k, 1'b0);
            wb(1'b1, 8'h4c, 32'h1 << lines[k], rd);
            cyc(3);
            chk(irq, 32'h0);
        end
    endtask

    task automatic t_prio;
        wb(1'b1, 8'h60, 32'h000040c0, rd);
        wb(1'b0, 8'h60, 32'h0, rd);
        chk(rd, 32'h000040c0);
        wb(1'b1, 8'h48, 32'h3, rd);
        cyc(3);
        chk({irq, id, prio}, {1'b1, 6'd1, 2'd1});
        wb(1'b1, 8'h4c, 32'h3, rd);
        wb(1'b1, 8'h48, 32'h200, rd);
        cyc(3);
        chk(irq, 32'h0);
        wb(1'b0, 8'h4c, 32'h0, rd);
        chk(rd, 32'h200);
        wb(1'b1, 8'h40, 32'h200, rd);
        cyc(3);
        chk({irq, id}, {1'b1, 6'd9});
        chk(act, 32'h200);
        wb(1'b0, 8'h50, 32'h0, rd);
        chk(rd, 32'h200);
        wb(1'b1, 8'h44, 32'h200, rd);
        cyc(3);
        chk(irq, 32'h0);
        wb(1'b1, 8'h4c, 32'h200, rd);
    endtask

    task automatic t_nmi;
        nmi <= 1'b1;
        @(negedge clk);
        chk({nmi_o, irq}, 32'h2);
        @(posedge clk);
        nmi <= 1'b0;
        @(negedge clk);
        chk(nmi_o, 32'h0);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_cnt_regs();
        t_cnt_irq();
        t_map();
        t_prio();
        t_nmi();
        end_of_test();
    end

    // The sequence needs well under two thousand cycles.
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end
endmodule // test_peripheral_interrupt_routing
